// ### pkg/wdrd_pkg.sv
// Purpose: Shared constants and types for the runaway-detecting watchdog.
// Assumes: AHB-Lite word registers, one 20 MHz system clock.
// Notes: Mode register layout is carried by a packed struct.
package wdrd_pkg;

  // Register byte offsets
  localparam logic [7:0] WDRD_OFS_MODE = 8'h00;
  localparam logic [7:0] WDRD_OFS_SVC = 8'h04;
  localparam logic [7:0] WDRD_OFS_STAT = 8'h08;
  localparam logic [7:0] WDRD_OFS_MASK = 8'h0c;
  localparam logic [7:0] WDRD_OFS_CNT = 8'h10;

  // Service codes
  localparam logic [7:0] WDRD_CODE_DISABLE = 8'hb1;
  localparam logic [7:0] WDRD_CODE_CLEAR = 8'h4e;

  // Mode register: enable, period select, reserved, idle run, reset select, reserved
  typedef struct packed {
    logic en;
    logic [2:0] per;
    logic rsv3;
    logic idle_run;
    logic rst_sel;
    logic rsv0;
  } wdrd_mode_t;

  localparam logic [7:0] WDRD_MODE_RST = 8'h82;
  localparam logic [7:0] WDRD_MODE_WMASK = 8'hf6;

  // Status and mask layout
  localparam int WDRD_STAT_NMI_BIT = 0;
  localparam logic [0:0] WDRD_STAT_RST = 1'h0;
  localparam logic [0:0] WDRD_MASK_RST = 1'h0;

  // Period: 2^(BASE + STEP*sel) cycles, codes above MAX clamp to the longest
  localparam int WDRD_PER_BASE = 15;
  localparam int WDRD_PER_STEP = 2;
  localparam logic [2:0] WDRD_PER_MAX = 3'h5;
  localparam int WDRD_CNT_W = 25;

  // Internal reset length in system clock states
  localparam int WDRD_RST_HOLD_CYC = 32;

  // Captured AHB address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } wdrd_aphase_t;

endpackage : wdrd_pkg

// ### verification/wdrd_top_tb.sv
// Purpose: Self-checking bench for the runaway watchdog over AHB-Lite.
// Assumes: Bench is the only bus master; hready is fed back from hreadyout.
// Notes: Two full 2^15 periods dominate the run, about 66k cycles.
module wdrd_top_tb import wdrd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, idle_i = 1'b0, debug_i = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, c0, dl, mode_m, seed;
  logic hreadyout, hresp, watchdog_interrupt, sys_reset_req, clk_reinit, irq, ck;
  int error_cnt = 0, check_count = 0, cyc = 0, n;
  always #25 hclk = ~hclk;
  always @(posedge hclk) cyc <= cyc + 1;
  wdrd_top i_wdrd_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .idle_i(idle_i),
    .debug_i(debug_i), .watchdog_interrupt(watchdog_interrupt),
    .sys_reset_req(sys_reset_req), .clk_reinit(clk_reinit), .irq(irq));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk32
  task automatic chk1(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1
  // Waits are bounded so a stuck slave cannot hang the bench
  task automatic wait_rdy;
    int t = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && t < 20) begin
      @(posedge hclk);
      t++;
    end
    if (t == 20) error_cnt++;
  endtask : wait_rdy
  // Called at a rising edge; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : bus
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk32($sformatf("reg %h", a), e, rd);
  endtask : rdchk
  task automatic wmode(input logic [31:0] d);
    mode_m = d & {24'h0, WDRD_MODE_WMASK};
    bus(1'b1, WDRD_OFS_MODE, d);
  endtask : wmode
  // Counter advance across two reads (3 edges) or read, service write, read (5 edges)
  task automatic delta(input logic sv, input logic [7:0] code);
    bus(1'b0, WDRD_OFS_CNT, 32'h0);
    c0 = rd;
    if (sv) bus(1'b1, WDRD_OFS_SVC, {24'h0, code});
    bus(1'b0, WDRD_OFS_CNT, 32'h0);
    dl = rd - c0;
  endtask : delta
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    #(50 * 80000);
    error_cnt++;
    end_sim();
  end
  initial begin
    mode_m = 32'h82;
    seed = 32'd76307;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(WDRD_OFS_MODE, mode_m);
    rdchk(WDRD_OFS_STAT, 32'h0);
    rdchk(WDRD_OFS_SVC, 32'h0);
    bus(1'b1, 8'h20, xs(seed));
    rdchk(8'h20, 32'h0);
    delta(1'b0, 8'h0);
    chk32("run", 32'd3, dl);
    $display("test reset and map done");
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      delta(1'b1, seed[7:0] ^ {7'h0, seed[7:0] == 8'hb1 || seed[7:0] == 8'h4e});
      chk32("reserved", 32'd5, dl);
    end
    delta(1'b1, WDRD_CODE_DISABLE);
    chk32("locked", 32'd5, dl);
    delta(1'b1, WDRD_CODE_CLEAR);
    chk1("clear", 1'b1, rd <= 32'd2);
    $display("test service codes done");
    debug_i <= 1'b1;
    delta(1'b0, 8'h0);
    chk32("debug", 32'd0, dl);
    debug_i <= 1'b0;
    idle_i <= 1'b1;
    delta(1'b0, 8'h0);
    chk32("idle stop", 32'd0, dl);
    wmode(32'h86);
    delta(1'b0, 8'h0);
    chk32("idle run", 32'd3, dl);
    idle_i <= 1'b0;
    $display("test halt modes done");
    wmode(32'h02);
    delta(1'b1, WDRD_CODE_DISABLE);
    chk1("off", 1'b1, rd <= 32'd1);
    delta(1'b0, 8'h0);
    chk32("off", 32'd0, dl);
    seed = xs(seed);
    wmode(seed);
    rdchk(WDRD_OFS_MODE, mode_m);
    wmode(32'h80);
    delta(1'b0, 8'h0);
    chk32("on", 32'd3, dl);
    $display("test disable done");
    bus(1'b1, WDRD_OFS_MASK, 32'h1);
    bus(1'b1, WDRD_OFS_SVC, {24'h0, WDRD_CODE_CLEAR});
    n = cyc;
    while (watchdog_interrupt !== 1'b1 && cyc - n < 40000) @(posedge hclk);
    chk32("nmi time", 32'd32769, cyc - n);
    n = cyc;
    rdchk(WDRD_OFS_STAT, 32'h1);
    chk1("irq", 1'b1, irq);
    bus(1'b1, WDRD_OFS_MASK, 32'h0);
    rdchk(WDRD_OFS_MASK, 32'h0);
    chk1("irq masked", 1'b0, irq);
    bus(1'b1, WDRD_OFS_STAT, 32'h1);
    rdchk(WDRD_OFS_STAT, 32'h0);
    wmode(32'h82);
    $display("test interrupt done");
    // Counter cleared at the first overflow, so the next one is a full period later
    while (sys_reset_req !== 1'b1 && cyc - n < 40000) @(posedge hclk);
    chk32("wrap", 32'd32768, cyc - n);
    n = cyc;
    while (sys_reset_req === 1'b1 && cyc - n < 100) @(posedge hclk);
    chk32("reset len", 32'd32, cyc - n);
    ck = clk_reinit;
    @(posedge hclk);
    chk1("reinit", 1'b1, ck | clk_reinit);
    mode_m = 32'h82;
    rdchk(WDRD_OFS_MODE, mode_m);
    delta(1'b0, 8'h0);
    chk32("restart", 32'd3, dl);
    $display("test internal reset done");
    end_sim();
  end
endmodule : wdrd_top_tb

// ### verilog/wdrd_top.sv
// Purpose: Watchdog that detects processor runaway and raises NMI or internal reset.
// Assumes: idle and debug indications come from logic on hclk; software is sole partner.
// Notes: Writes are zero wait; reads insert one wait state so data is never stale.
// Functional notes
// - Service code byte is write-only; 0xB1 disables, 0x4E clears, others reserved.
// - Binary counter on system clock; period 2^15..2^25 chosen by period select.
// - Overflow with reset select 0 raises the watchdog NMI.
// - Watchdog NMI sets the watchdog flag in the NMI source flag register.
// - Overflow with reset select 1 asserts 32-cycle internal reset, then clock reinit.
// - Counting starts immediately after any reset release.
// - In IDLE the idle-run bit decides counting; debug stops it.
// - Counter halts while the processor is in debug mode.
// - Period select resets to 000, the shortest period.
// - Enable bit resets to 1, watchdog running.
// - Disable needs enable cleared first, then 0xB1; counter is then cleared.
// - Writing enable bit 1 re-enables the watchdog, no unlock code.
// - Reset select resets to 1, overflow gives internal reset.
// - Writing 0x4E clears the counter, which resumes from zero.
// - Period select 011 gives 2^21 cycles.
// - Mode bits: enable 7, period 6..4, idle run 2, reset select 1; 110/111 prohibited.
module wdrd_top
  import wdrd_pkg::*;
#(
  parameter int CNT_W = WDRD_CNT_W
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Processor state
  input wire logic idle_i,
  input wire logic debug_i,
  // Watchdog outputs
  output logic watchdog_interrupt,
  output logic sys_reset_req,
  output logic clk_reinit,
  output logic irq
);

  // Bus state
  wdrd_aphase_t ap_q;
  logic rd_wait_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;

  // Watchdog state
  wdrd_mode_t mode_q;
  logic run_q;
  logic [CNT_W-1:0] cnt_q;
  logic [5:0] hold_q;
  logic sys_reset_q;
  logic clk_reinit_q;
  logic nmi_q;
  logic [0:0] stat_q;
  logic [0:0] mask_q;
  logic irq_q;

  // Period mask: counter overflows when all bits below the period are ones
  function automatic logic [CNT_W-1:0] wdrd_per_mask(input logic [2:0] sel);
    logic [2:0] s;
    int n;
    s = (sel > WDRD_PER_MAX) ? WDRD_PER_MAX : sel;
    n = WDRD_PER_BASE + WDRD_PER_STEP * int'(s);
    wdrd_per_mask = CNT_W'((64'h1 << n) - 64'h1);
  endfunction : wdrd_per_mask

  // Address decode
  wire addr_take = hsel && htrans[1] && hready;
  wire wr_phase = ap_q.valid && ap_q.write;
  wire wr_mode = wr_phase && (ap_q.addr == WDRD_OFS_MODE);
  wire wr_svc = wr_phase && (ap_q.addr == WDRD_OFS_SVC);
  wire wr_stat = wr_phase && (ap_q.addr == WDRD_OFS_STAT);
  wire wr_mask = wr_phase && (ap_q.addr == WDRD_OFS_MASK);
  wire [7:0] svc_code = hwdata[7:0];
  wire svc_clear = wr_svc && (svc_code == WDRD_CODE_CLEAR);
  wire svc_dis_code = wr_svc && (svc_code == WDRD_CODE_DISABLE);
  // Unlock only takes effect once the enable bit already reads 0
  wire svc_disable = svc_dis_code && !mode_q.en;
  wire en_write_one = wr_mode && hwdata[7];
  wire holding = sys_reset_q;

  // Counting conditions
  wire idle_ok = !idle_i || mode_q.idle_run;
  wire count_en = run_q && !debug_i && idle_ok && !holding;
  wire [CNT_W-1:0] per_mask = wdrd_per_mask(mode_q.per);
  wire at_top = ((cnt_q & per_mask) == per_mask);
  // A clear in the same cycle counts as a timely service and cancels the overflow
  wire ovf = count_en && at_top && !svc_clear && !svc_disable;
  wire ovf_nmi = ovf && !mode_q.rst_sel;
  wire ovf_rst = ovf && mode_q.rst_sel;
  wire hold_end = holding && (hold_q == 6'(WDRD_RST_HOLD_CYC - 1));

  // Read mux
  wire [31:0] rd_val =
      (ap_q.addr == WDRD_OFS_MODE) ? {24'h0, mode_q} :
      (ap_q.addr == WDRD_OFS_STAT) ? {31'h0, stat_q} :
      (ap_q.addr == WDRD_OFS_MASK) ? {31'h0, mask_q} :
      (ap_q.addr == WDRD_OFS_CNT) ? 32'(cnt_q) :
      32'h0;

  // Status next value: hardware set wins over software clear
  wire [0:0] stat_d = (wr_stat ? (stat_q & ~hwdata[0:0]) : stat_q) | {ovf_nmi};
  wire [0:0] mask_d = wr_mask ? hwdata[0:0] : mask_q;

  // AHB address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= '0;
    end else if (hready) begin
      ap_q <= '{valid: addr_take, write: hwrite, addr: {haddr[7:2], 2'h0}};
    end
  end

  // Reads take one wait state; hsize is accepted as word for all accesses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_wait_q <= 1'b0;
      hreadyout_q <= 1'b1;
      hrdata_q <= 32'h0;
    end else if (addr_take && !hwrite) begin
      rd_wait_q <= 1'b1;
      hreadyout_q <= 1'b0;
    end else if (rd_wait_q) begin
      rd_wait_q <= 1'b0;
      hreadyout_q <= 1'b1;
      hrdata_q <= rd_val;
    end
  end

  // Mode register; a completed internal reset restores the defaults
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= wdrd_mode_t'(WDRD_MODE_RST);
    end else if (hold_end) begin
      mode_q <= wdrd_mode_t'(WDRD_MODE_RST);
    end else if (wr_mode) begin
      mode_q <= wdrd_mode_t'(hwdata[7:0] & WDRD_MODE_WMASK);
    end
  end

  // Run state: clearing the enable bit alone keeps the watchdog running
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q <= 1'b1;
    end else if (hold_end || en_write_one) begin
      run_q <= 1'b1;
    end else if (svc_disable) begin
      run_q <= 1'b0;
    end
  end

  // Binary counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
    end else if (svc_clear || svc_disable || ovf || holding) begin
      cnt_q <= '0;
    end else if (count_en) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // Internal reset hold and clock reinit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sys_reset_q <= 1'b0;
      hold_q <= 6'h00;
      clk_reinit_q <= 1'b0;
    end else begin
      clk_reinit_q <= hold_end;
      if (ovf_rst) begin
        sys_reset_q <= 1'b1;
        hold_q <= 6'h00;
      end else if (hold_end) begin
        sys_reset_q <= 1'b0;
      end else if (holding) begin
        hold_q <= hold_q + 6'h01;
      end
    end
  end

  // NMI pulse, source flag, mask and interrupt
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nmi_q <= 1'b0;
      stat_q <= WDRD_STAT_RST;
      mask_q <= WDRD_MASK_RST;
      irq_q <= 1'b0;
    end else begin
      nmi_q <= ovf_nmi;
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q <= |(stat_d & mask_d);
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;
  assign watchdog_interrupt = nmi_q;
  assign sys_reset_req = sys_reset_q;
  assign clk_reinit = clk_reinit_q;
  assign irq = irq_q;

  // Checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_rst_hold;
    sys_reset_q [*8] ##24 sys_reset_q;
  endsequence

  sequence s_rst_release;
    !sys_reset_q && clk_reinit_q && (mode_q == wdrd_mode_t'(WDRD_MODE_RST)) && run_q;
  endsequence

  property p_clear;
    svc_clear |=> (cnt_q == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("clear code did not zero counter");

  property p_disable;
    svc_dis_code && !mode_q.en && !en_write_one |=> !run_q && (cnt_q == '0);
  endproperty
  a_disable: assert property (p_disable) else $error("unlock did not disable");

  property p_no_disable;
    svc_dis_code && mode_q.en |=> run_q;
  endproperty
  a_no_disable: assert property (p_no_disable) else $error("disabled without unlock");

  property p_reserved;
    wr_svc && !svc_clear && !svc_dis_code && !count_en && !holding && !wr_mode
      |=> $stable(cnt_q) && $stable(run_q);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code changed state");

  property p_nmi;
    ovf_nmi |=> nmi_q && stat_q[WDRD_STAT_NMI_BIT] && (cnt_q == '0) && !sys_reset_q;
  endproperty
  a_nmi: assert property (p_nmi) else $error("overflow did not raise nmi");

  property p_rst;
    ovf_rst |=> s_rst_hold ##1 s_rst_release;
  endproperty
  a_rst: assert property (p_rst) else $error("internal reset length wrong");

  property p_debug;
    debug_i && !svc_clear && !svc_disable && !holding |=> $stable(cnt_q);
  endproperty
  a_debug: assert property (p_debug) else $error("counter moved in debug");

  property p_idle;
    idle_i && !mode_q.idle_run && !svc_clear && !svc_disable && !holding |=> $stable(cnt_q);
  endproperty
  a_idle: assert property (p_idle) else $error("counter moved in idle");

  property p_count;
    count_en && !at_top && !svc_clear && !svc_disable |=> cnt_q == $past(cnt_q) + CNT_W'(1);
  endproperty
  a_count: assert property (p_count) else $error("counter failed to advance");

  property p_irq;
    irq_q == |(stat_q & mask_q);
  endproperty
  a_irq: assert property (p_irq) else $error("irq does not follow status and mask");

endmodule : wdrd_top
